// *** core/spfm_pkg.sv ***
// Constants, pad slot table and helpers for the shared pin function mux
`default_nettype none
package spfm_pkg;

  // ==========================================================================
  // Sizes
  localparam int PAD_COUNT = 58;   // Shared pads, general-purpose lines 0..57
  localparam int PAD_W     = 6;    // Width of a pad index
  localparam int SLOT_N    = 3;    // Peripheral slots per pad besides GPIO
  localparam int SPI_N     = 2;    // SPI controllers with movable data pins
  localparam int SPI_SIG_N = 4;    // din, dout, wp, hold

  // ==========================================================================
  // Function select codes
  localparam logic [1:0] FSEL_GPIO = 2'h0;   // General-purpose function
  localparam logic [1:0] FSEL_PRI  = 2'h1;   // Primary peripheral (slot 0)
  localparam logic [1:0] FSEL_ALT1 = 2'h2;   // First alternate (slot 1)
  localparam logic [1:0] FSEL_ALT2 = 2'h3;   // Second alternate (slot 2)

  // ==========================================================================
  // Fixed pad positions
  localparam int PAD_CAM_LO   = 8;    // Camera pixel data pads 8..11
  localparam int PAD_CAM_HI   = 11;
  localparam int PAD_BOOT     = 0;    // Boot-mode strap pad
  localparam int PAD_USB_DET  = 49;   // Dedicated cable-detect input
  localparam int PAD_SPI_G0   = 37;   // Group 0 runs upward 37..40
  localparam int PAD_SPI_G1   = 46;   // Group 1 runs downward 46..43

  // ==========================================================================
  // Reset and idle values
  localparam logic       SPI_GRP_RESET = 1'b0;      // Both controllers on 37..40
  localparam logic [3:0] SPI_IN_IDLE   = 4'hc;      // wp and hold idle high
  localparam logic       GPIO_IN_IDLE  = 1'b0;
  // Idle input level per pad-slot; active-low selects on pads 25 and 30 idle high
  localparam logic [PAD_COUNT-1:0][SLOT_N-1:0] FN_IN_IDLE =
    (174)'(3'h1) << (3 * 25) | (174)'(3'h1) << (3 * 30);

  // ==========================================================================
  // Reset function of a pad
  function automatic logic [1:0] spfm_reset_fsel(input int p);
    if (p >= PAD_CAM_LO && p <= PAD_CAM_HI)
      return FSEL_PRI;
    return FSEL_GPIO;
  endfunction : spfm_reset_fsel

  // Whether a function code exists on a pad
  function automatic logic spfm_slot_ok(input int p, input logic [1:0] f);
    logic [2:0] ok;
    ok = 3'h1;                                   // Single primary peripheral
    if (p >= 4 && p <= 7)   ok = 3'h7;           // Debug, second UART, PWM
    if (p == 29 || p == 47) ok = 3'h3;
    if (p == 30)            ok = 3'h7;
    if ((p >= 37 && p <= 40) || (p >= 43 && p <= 46)) ok = 3'h7;
    if (p == PAD_USB_DET)   ok = 3'h0;           // Input-only pad
    if (f == FSEL_GPIO)
      return 1'b1;
    return ok[f - 2'h1];
  endfunction : spfm_slot_ok

  // Pad index carrying SPI data signal k in group g
  function automatic logic [PAD_W-1:0] spfm_spi_pad(input logic g, input int k);
    if (g)
      return PAD_W'(PAD_SPI_G1 - k);
    return PAD_W'(PAD_SPI_G0 + k);
  endfunction : spfm_spi_pad

endpackage : spfm_pkg

`default_nettype wire

// *** core/spfm_core.sv ***
// Shared pin function mux: routes each pad to GPIO or a peripheral function
`timescale 1ns/1ps
`default_nettype none

module spfm_core
#(
  parameter int NPADS = spfm_pkg::PAD_COUNT
)(
  // Clock and reset
  input  wire logic                                   mclk,
  input  wire logic                                   rst_n,
  // Function select write port
  input  wire logic                                   cfg_wr_en,
  input  wire logic [spfm_pkg::PAD_W-1:0]             cfg_wr_pad,
  input  wire logic [1:0]                             cfg_wr_fsel,
  input  wire logic                                   cfg_spi_wr_en,
  input  wire logic [spfm_pkg::SPI_N-1:0]             cfg_spi_grp,
  // Configuration readback
  output logic [NPADS-1:0][1:0]                       fsel_rd,
  output logic [spfm_pkg::SPI_N-1:0]                  spi_grp_rd,
  output logic                                        cfg_refused,
  // General-purpose controller side
  input  wire logic [NPADS-1:0]                       gpio_out,
  input  wire logic [NPADS-1:0]                       gpio_oe,
  output logic [NPADS-1:0]                            gpio_in,
  // Peripheral slots, three per pad
  input  wire logic [NPADS-1:0][spfm_pkg::SLOT_N-1:0] fn_out,
  input  wire logic [NPADS-1:0][spfm_pkg::SLOT_N-1:0] fn_oe,
  output logic [NPADS-1:0][spfm_pkg::SLOT_N-1:0]      fn_in,
  // SPI data signals (din, dout, wp, hold) per controller
  input  wire logic [spfm_pkg::SPI_N-1:0][3:0]        spi_out,
  input  wire logic [spfm_pkg::SPI_N-1:0][3:0]        spi_oe,
  output logic [spfm_pkg::SPI_N-1:0][3:0]             spi_in,
  // Pads
  input  wire logic [NPADS-1:0]                       pad_in,
  output logic [NPADS-1:0]                            pad_out,
  output logic [NPADS-1:0]                            pad_oe,
  // Status to boot logic and cable detector
  output logic                                        boot_sel,
  output logic                                        boot_sel_valid,
  output logic                                        usb_detect
);

  import spfm_pkg::*;

  // ==========================================================================
  // Elaboration check: the slot table is fixed to the documented pad count
  if (NPADS != PAD_COUNT)
  begin : g_bad_npads
    $error("spfm_core: NPADS must equal the pad table size");
  end

  // ==========================================================================
  // State
  logic [NPADS-1:0][1:0]              fsel_q;
  logic [SPI_N-1:0]                   spi_grp_q;
  logic [NPADS-1:0]                   sync1_q;
  logic [NPADS-1:0]                   sync2_q;
  logic [NPADS-1:0]                   pad_out_d;
  logic [NPADS-1:0]                   pad_oe_d;
  logic [NPADS-1:0]                   gpio_in_d;
  logic [NPADS-1:0][SLOT_N-1:0]       fn_in_d;
  logic [SPI_N-1:0][3:0]              spi_in_d;
  logic                               wr_ok;

  // Write is taken only for an existing pad and a function it really has
  assign wr_ok = (int'(cfg_wr_pad) < NPADS) && spfm_slot_ok(int'(cfg_wr_pad), cfg_wr_fsel);

  // ==========================================================================
  // Function select fields; codes for a slot the pad lacks are refused and the field keeps its value
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int p = 0; p < NPADS; p++)
        fsel_q[p] <= spfm_reset_fsel(p);
    end
    else if (cfg_wr_en && wr_ok)
    begin
      fsel_q[cfg_wr_pad] <= cfg_wr_fsel;
    end
  end

  // SPI data group choice per controller
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      spi_grp_q <= {SPI_N{SPI_GRP_RESET}};
    else if (cfg_spi_wr_en)
      spi_grp_q <= cfg_spi_grp;
  end

  // Refusal flag, one cycle after the rejected write
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cfg_refused <= 1'b0;
    else
      cfg_refused <= cfg_wr_en && !wr_ok;
  end

  // ==========================================================================
  // Pad input synchronisers: pads are asynchronous to mclk
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================================
  // Output path: the owner selected by the field drives the pad
  always_comb
  begin
    logic [PAD_W-1:0] sp;
    sp = '0;
    for (int p = 0; p < NPADS; p++)
    begin
      if (fsel_q[p] == FSEL_GPIO)
      begin
        pad_out_d[p] = gpio_out[p];
        pad_oe_d[p]  = gpio_oe[p];
      end
      else
      begin
        pad_out_d[p] = fn_out[p][fsel_q[p] - 2'h1];
        pad_oe_d[p]  = fn_oe[p][fsel_q[p] - 2'h1];
      end
    end
    // SPI data pads take the controller's own lines, only in its chosen group
    for (int g = 0; g < 2; g++)
    begin
      for (int k = 0; k < SPI_SIG_N; k++)
      begin
        sp = spfm_spi_pad(g[0], k);
        if (fsel_q[sp] == FSEL_ALT1 || fsel_q[sp] == FSEL_ALT2)
        begin
          if (spi_grp_q[fsel_q[sp][0]] == g[0])
          begin
            pad_out_d[sp] = spi_out[fsel_q[sp][0]][k];
            pad_oe_d[sp]  = spi_oe[fsel_q[sp][0]][k];
          end
          else
          begin
            pad_out_d[sp] = 1'b0;                   // Controller lives in the other group
            pad_oe_d[sp]  = 1'b0;
          end
        end
      end
    end
    pad_oe_d[PAD_USB_DET] = 1'b0;
  end

  // ==========================================================================
  // Input path: the selected slot sees the pad, others see idle; on SPI data pads its SPI controller sees it too, only in its chosen group
  always_comb
  begin
    logic [PAD_W-1:0] sp;
    sp = '0;
    for (int p = 0; p < NPADS; p++)
    begin
      gpio_in_d[p] = (fsel_q[p] == FSEL_GPIO) ? sync2_q[p] : GPIO_IN_IDLE;
      for (int s = 0; s < SLOT_N; s++)
        fn_in_d[p][s] = (fsel_q[p] == 2'(s + 1)) ? sync2_q[p] : FN_IN_IDLE[p][s];
    end
    for (int c = 0; c < SPI_N; c++)
    begin
      for (int k = 0; k < SPI_SIG_N; k++)
      begin
        sp = spfm_spi_pad(spi_grp_q[c], k);
        if (fsel_q[sp] == 2'(c + 2))
          spi_in_d[c][k] = sync2_q[sp];
        else
          spi_in_d[c][k] = SPI_IN_IDLE[k];
      end
    end
  end

  // ==========================================================================
  // Registered outputs; pads stay undriven during reset
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pad_out <= '0;
      pad_oe  <= '0;
      gpio_in <= '0;
      fn_in   <= FN_IN_IDLE;
      spi_in  <= {SPI_N{SPI_IN_IDLE}};
    end
    else
    begin
      pad_out <= pad_out_d;
      pad_oe  <= pad_oe_d;
      gpio_in <= gpio_in_d;
      fn_in   <= fn_in_d;
      spi_in  <= spi_in_d;
    end
  end

  // Readback and status copies
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      fsel_rd        <= '0;
      spi_grp_rd     <= '0;
      boot_sel       <= 1'b0;
      boot_sel_valid <= 1'b0;
      usb_detect     <= 1'b0;
    end
    else
    begin
      fsel_rd        <= fsel_q;
      spi_grp_rd     <= spi_grp_q;
      boot_sel       <= sync2_q[PAD_BOOT];
      boot_sel_valid <= (fsel_q[PAD_BOOT] == FSEL_GPIO);
      usb_detect     <= sync2_q[PAD_USB_DET];
    end
  end

endmodule : spfm_core

`default_nettype wire

// *** verif/spfm_pad_model.sv ***
// Pad world model: a pad reads back its own drive, else the external level
`timescale 1ns/1ps
`default_nettype none
module spfm_pad_model (
  // Pad side of the mux
  input  wire logic [57:0] pad_out,
  input  wire logic [57:0] pad_oe,
  // External level of each released pad
  input  wire logic [57:0] ext_lvl,
  output logic      [57:0] pad_in
);
  // A released pad never keeps the last driven value
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule : spfm_pad_model
`default_nettype wire

// *** verif/spfm_assertions.sv ***
// Port checks for the shared pin function mux
`timescale 1ns/1ps
`default_nettype none
module spfm_assertions
  import spfm_pkg::*;
#(
  parameter int NPADS = 58
)(
  // Clock, reset and write port
  input wire logic                         mclk,
  input wire logic                         rst_n,
  input wire logic                         cfg_wr_en,
  input wire logic [spfm_pkg::PAD_W-1:0]   cfg_wr_pad,
  input wire logic [1:0]                   cfg_wr_fsel,
  // Mux outputs and drives
  input wire logic [NPADS-1:0][1:0]        fsel_rd,
  input wire logic                         cfg_refused,
  input wire logic [NPADS-1:0]             gpio_out,
  input wire logic [NPADS-1:0]             gpio_oe,
  input wire logic [NPADS-1:0][spfm_pkg::SLOT_N-1:0] fn_out,
  input wire logic [NPADS-1:0]             pad_in,
  input wire logic [NPADS-1:0]             pad_out,
  input wire logic [NPADS-1:0]             pad_oe,
  input wire logic                         boot_sel,
  input wire logic                         boot_sel_valid,
  input wire logic                         usb_detect
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ====
  // Reset history: synchroniser outputs are only meaningful after three clean edges
  logic [2:0] up_q;
  always_ff @(posedge mclk)
    up_q <= {up_q[1:0], rst_n};
  sequence s_wr_gpio;
    cfg_wr_en && cfg_wr_pad < 6'd58 && cfg_wr_fsel == 2'h0 ##1 !cfg_wr_en;
  endsequence
  a_reset_fields: assert property ($rose(rst_n) |=> fsel_rd[11:8] == {4{2'h1}} &&
    fsel_rd[7:0] == '0 && fsel_rd[57:12] == '0) else $error("reset function wrong");
  a_wr_gpio: assert property (s_wr_gpio |=> fsel_rd[$past(cfg_wr_pad, 2)] == 2'h0)
    else $error("write not taken");
  for (genvar p = 0; p < NPADS; p++)
  begin : g_pad
    if (p != 49)
    begin : g_io
      a_gpio_route: assert property ($past(rst_n) && fsel_rd[p] == 2'h0 |->
        pad_out[p] == $past(gpio_out[p]) && pad_oe[p] == $past(gpio_oe[p]))
        else $error("gpio route wrong");
    end
  end
  a_pri_route: assert property ($past(rst_n) && fsel_rd[20] == 2'h1 |->
    pad_out[20] == $past(fn_out[20][0])) else $error("primary route wrong");
  a_usb_quiet: assert property (pad_oe[49] == 1'b0) else $error("pad 49 driven");
  a_refuse_bad: assert property (cfg_wr_en && (cfg_wr_pad > 6'd57 ||
    (cfg_wr_pad == 6'd49 && cfg_wr_fsel != 2'h0)) |=> cfg_refused) else $error("no refusal");
  a_no_refuse: assert property (!cfg_wr_en |=> !cfg_refused) else $error("stray refusal");
  a_boot_sample: assert property (up_q == 3'h7 |-> boot_sel == $past(pad_in[0], 3))
    else $error("boot select lag wrong");
  a_usb_sample: assert property (up_q == 3'h7 |-> usb_detect == $past(pad_in[49], 3))
    else $error("cable detect lag wrong");
  a_boot_valid: assert property ($past(rst_n) |-> boot_sel_valid == (fsel_rd[0] == 2'h0))
    else $error("boot valid wrong");
endmodule : spfm_assertions
bind spfm_core spfm_assertions #(.NPADS(NPADS)) spfm_assertions_inst (.mclk(mclk), .rst_n(rst_n),
  .cfg_wr_en(cfg_wr_en), .cfg_wr_pad(cfg_wr_pad), .cfg_wr_fsel(cfg_wr_fsel), .fsel_rd(fsel_rd),
  .cfg_refused(cfg_refused), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .fn_out(fn_out),
  .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .boot_sel(boot_sel),
  .boot_sel_valid(boot_sel_valid), .usb_detect(usb_detect));
`default_nettype wire

// *** verif/test_spfm_core.sv ***
// Self-checking bench for the shared pin function mux
`timescale 1ns/1ps
`default_nettype none
module test_spfm_core;
  import spfm_pkg::*;
  // ====
  // Stimulus; slot drives differ so each peripheral slot gives its own pad pattern
  logic mclk = 1'b0, rst_n = 1'b0, cfg_wr_en = 1'b0, cfg_spi_wr_en = 1'b0;
  logic [5:0] cfg_wr_pad = '0;
  logic [1:0] cfg_wr_fsel = '0, cfg_spi_grp = '0, spi_grp_rd;
  // GPIO drives all high, enabled on pad 50 only, so GPIO pads other than 50 show the same pattern as slot 2
  logic [57:0] gpio_out = '1, gpio_oe = 58'h4000000000000, ext_lvl = '0;
  logic [57:0] gpio_in, pad_in, pad_out, pad_oe;
  logic [57:0][2:0] fn_out = {58{3'h5}}, fn_oe = {58{3'h3}}, fn_in;
  logic [1:0][3:0] spi_out = '0, spi_oe = '0, spi_in;
  logic [57:0][1:0] fsel_rd;
  logic cfg_refused, boot_sel, boot_sel_valid, usb_detect;
  int fail_count = 0, total_checks = 0;
  always #5 mclk = ~mclk;
  spfm_core #(.NPADS(58)) spfm_core_inst (.mclk(mclk), .rst_n(rst_n), .cfg_wr_en(cfg_wr_en),
    .cfg_wr_pad(cfg_wr_pad), .cfg_wr_fsel(cfg_wr_fsel), .cfg_spi_wr_en(cfg_spi_wr_en),
    .cfg_spi_grp(cfg_spi_grp), .fsel_rd(fsel_rd), .spi_grp_rd(spi_grp_rd),
    .cfg_refused(cfg_refused), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
    .fn_out(fn_out), .fn_oe(fn_oe), .fn_in(fn_in), .spi_out(spi_out), .spi_oe(spi_oe),
    .spi_in(spi_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .boot_sel(boot_sel),
    .boot_sel_valid(boot_sel_valid), .usb_detect(usb_detect));
  spfm_pad_model spfm_pad_model_inst (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext_lvl),
    .pad_in(pad_in));
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] s);
    total_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // One write pulse; ends on the edge that takes it
  task automatic wr(input logic [5:0] p, input logic [1:0] c);
    @(posedge mclk);
    cfg_wr_pad <= p;
    cfg_wr_fsel <= c;
    cfg_wr_en <= 1'b1;
    @(posedge mclk);
    cfg_wr_en <= 1'b0;
  endtask : wr
  task automatic sc_reset;
    tick(2);
    for (int p = 0; p < 58; p++)
      chk("fsel", {3'h0, p >= 8 && p <= 11}, fsel_rd[p]);
  endtask : sc_reset
  task automatic sc_routes;
    // Entries are code and pad; the pad shows {oe, out} of the chosen slot
    logic [7:0] rt [20] = '{8'h44, 8'h85, 8'hc7, 8'h40, 8'h43, 8'h41,
      8'h4c, 8'h54, 8'h58, 8'h5a, 8'h5c, 8'h9d, 8'hde, 8'h60,
      8'h6a, 8'haf, 8'h78, 8'h75, 8'h79, 8'h0a};
    for (int i = 0; i < 20; i++)
    begin
      wr(rt[i][5:0], rt[i][7:6]);
      tick(2);
      chk("route", rt[i][7:6] == 2'h0 ? 4'h1 : 4'h4 - rt[i][7:6],
        {pad_oe[rt[i][5:0]], pad_out[rt[i][5:0]]});
    end
    chk("gpio50", 4'h3, {pad_oe[50], pad_out[50]});
  endtask : sc_routes
  task automatic sc_refuse;
    // Entries are expected refusal, code and pad
    logic [8:0] rf [5] = '{9'h17a, 9'h171, 9'h1dd, 9'h1ef, 9'h09d};
    for (int i = 0; i < 5; i++)
    begin
      wr(rf[i][5:0], rf[i][7:6]);
      #1;                                   // The refusal pulse stands for one cycle only
      chk("refused", rf[i][8], cfg_refused);
    end
    chk("fsel49", 4'h0, fsel_rd[49]);
    chk("fsel29", 4'h2, fsel_rd[29]);
  endtask : sc_refuse
  task automatic sc_inputs;
    @(posedge mclk);
    ext_lvl <= (58'h1 << 9) | (58'h1 << 49) | 58'h1;
    wr(6'd0, 2'h0);
    tick(4);
    chk("cam", 4'h1, {gpio_in[9], fn_in[9][0]});
    chk("idle", 4'h1, {gpio_in[25], fn_in[25][0]});
    chk("usb", 4'h1, usb_detect);
    chk("gpioin", 4'h1, gpio_in[50]);
    chk("boot", 4'h3, {boot_sel, boot_sel_valid});
    wr(6'd0, 2'h1);
    tick(2);
    chk("bootv", 4'h0, boot_sel_valid);
  endtask : sc_inputs
  task automatic sc_spi;
    @(posedge mclk);
    spi_out <= {4'h2, 4'h2};
    spi_oe <= {4'h2, 4'h2};
    cfg_spi_grp <= 2'h2;
    cfg_spi_wr_en <= 1'b1;
    @(posedge mclk);
    cfg_spi_wr_en <= 1'b0;
    wr(6'd38, 2'h2);
    wr(6'd45, 2'h3);
    wr(6'd40, 2'h2);
    tick(4);
    chk("spi", 4'hf, {pad_oe[38], pad_out[38], pad_oe[45], pad_out[45]});
    chk("spiin", 4'h6, {spi_in[0][3], spi_in[1][3:2], spi_grp_rd[0]});
    @(posedge mclk);
    cfg_spi_grp <= 2'h1;
    cfg_spi_wr_en <= 1'b1;
    @(posedge mclk);
    cfg_spi_wr_en <= 1'b0;
    tick(2);
    chk("spimove", 4'h0, {pad_oe[38], pad_oe[45]});
  endtask : sc_spi
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    sc_reset();
    sc_routes();
    sc_refuse();
    sc_inputs();
    sc_spi();
    tally_and_finish();
  end
endmodule : test_spfm_core
`default_nettype wire
